// [common/wps_defs.vh]
`ifndef WPS_DEFS_VH
`define WPS_DEFS_VH
// Register word addresses on the serial port
`define WPS_REG_UPDATE 15'h001d
`define WPS_REG_STATUS 15'h001e
`define WPS_REG_TYPE 15'h001f
`define WPS_REG_DELAY 15'h0020
// Sample memory window on the serial port
`define WPS_MEM_SEL 3'b110
// Field positions
`define WPS_UPDATE_BIT 0
`define WPS_RUN_BIT 0
`define WPS_PATTERN_BIT 1
`define WPS_MEMACC_BIT 2
`define WPS_BUFREAD_BIT 3
`define WPS_RPT_BIT 0
// Reset values
`define WPS_STATUS_RST 4'h0
`define WPS_DELAY_RST 16'h0000
// Waveform source codes
`define WPS_SRC_MEM 2'h0
`define WPS_SRC_SINE 2'h1
`define WPS_SRC_SAW 2'h2
`define WPS_SRC_AM 2'h3
// Serial frame timing, in serial clock bits
`define WPS_SPI_CMD_LAST 5'h0f
`define WPS_SPI_DATA_FIRST 5'h10
`define WPS_SPI_LAST 5'h1f
// Gain of 1.0 sits at this fraction position
`define WPS_GAIN_FRAC 10
`define WPS_ENV_FRAC 13
`define WPS_SAW_MAX 14'h1fff
`endif

// [verilog/wps_seq_counter.v]
`timescale 1ns/1ps
`default_nettype none
module wps_seq_counter #(
  parameter WIDTH = 16
) (
  input wire core_clk,
  input wire rst_n,
  input wire clear,
  input wire enable,
  output reg [WIDTH-1:0] count
);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
    end else if (enable) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [verilog/wps_sequencer.v]
`timescale 1ns/1ps
`default_nettype none
`include "wps_defs.vh"
module wps_sequencer #(
  parameter ADDR_W = 12,
  parameter DATA_W = 14
) (
  input wire core_clk,
  input wire rst_n,
  input wire spiSclk,
  input wire spiCsN,
  input wire spiMosi,
  output reg spiMiso,
  output reg spiMisoEn,
  input wire [1:0] waveSel,
  input wire synthMsbClockSelect,
  input wire [ADDR_W-1:0] segFirstAddr,
  input wire [ADDR_W-1:0] segLastAddr,
  input wire [15:0] periodLength,
  input wire [7:0] repeatCycleCount,
  input wire [7:0] sineCycleCount,
  input wire [11:0] digitalGainFactor,
  input wire signed [DATA_W-1:0] synthSine,
  input wire synthMsb,
  output reg [DATA_W-1:0] sampleOut,
  output reg [DATA_W-1:0] tuningBits,
  output reg patternActive
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DELAY = 3'b010;
  localparam ST_PLAY = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port, pins synchronised before use
  reg [2:0] sclkSync;
  reg [1:0] csSync;
  reg [1:0] mosiSync;
  reg [4:0] bitCnt;
  reg [14:0] shiftIn;
  reg [14:0] shiftOut;
  reg [14:0] addrReg;
  reg rwReg;
  wire sclkRise = sclkSync[1] & ~sclkSync[2];
  wire sclkFall = ~sclkSync[1] & sclkSync[2];
  wire csActive = ~csSync[1];
  wire [15:0] frameWord = {shiftIn, mosiSync[1]};
  wire wrStrobe = csActive & sclkRise & (bitCnt == `WPS_SPI_LAST) & ~rwReg;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and memory
  reg runReg;
  reg memAccessReg;
  reg bufReadReg;
  reg repeatTypeReg;
  reg [15:0] delayShadowReg;
  reg [15:0] delayActiveReg;
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  reg [DATA_W-1:0] memData;
  reg [15:0] readData;
  wire isMem = addrReg[14:12] == `WPS_MEM_SEL;
  wire [ADDR_W-1:0] hostAddr = addrReg[ADDR_W-1:0];
  wire hostInSeg = (hostAddr >= segFirstAddr) && (hostAddr <= segLastAddr);
  wire hostMemOk = memAccessReg & (~runReg | ~hostInSeg);
  wire memWrite = wrStrobe & isMem & hostMemOk & ~bufReadReg;

  always @* begin
    readData = 16'h0000;
    if (isMem) begin
      if (hostMemOk & bufReadReg) begin
        readData = {{(16-DATA_W){1'b0}}, mem[hostAddr]};
      end
    end else begin
      case (addrReg)
        `WPS_REG_STATUS: readData = {12'h000, bufReadReg, memAccessReg, patternActive, runReg};
        `WPS_REG_TYPE: readData = {15'h0000, repeatTypeReg};
        `WPS_REG_DELAY: readData = delayShadowReg;
        default: readData = 16'h0000;
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSync <= 3'h0;
      csSync <= 2'h3;
      mosiSync <= 2'h0;
      bitCnt <= 5'h00;
      shiftIn <= 15'h0000;
      shiftOut <= 15'h0000;
      addrReg <= 15'h0000;
      rwReg <= 1'b0;
      spiMiso <= 1'b0;
      spiMisoEn <= 1'b0;
    end else begin
      sclkSync <= {sclkSync[1:0], spiSclk};
      csSync <= {csSync[0], spiCsN};
      mosiSync <= {mosiSync[0], spiMosi};
      spiMisoEn <= csActive & rwReg & (bitCnt >= `WPS_SPI_DATA_FIRST);
      if (!csActive) begin
        bitCnt <= 5'h00;
        rwReg <= 1'b0;
      end else if (sclkRise) begin
        bitCnt <= bitCnt + 5'h01;
        shiftIn <= frameWord[14:0];
        if (bitCnt == `WPS_SPI_CMD_LAST) begin
          rwReg <= frameWord[15];
          addrReg <= frameWord[14:0];
        end
      end else if (sclkFall && rwReg) begin
        // Data goes out on the falling edge so the master samples it on the rise
        if (bitCnt == `WPS_SPI_DATA_FIRST) begin
          spiMiso <= readData[15];
          shiftOut <= readData[14:0];
        end else if (bitCnt > `WPS_SPI_DATA_FIRST) begin
          spiMiso <= shiftOut[14];
          shiftOut <= {shiftOut[13:0], 1'b0};
        end
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      runReg <= 1'b0;
      memAccessReg <= 1'b0;
      bufReadReg <= 1'b0;
      repeatTypeReg <= 1'b0;
      delayShadowReg <= `WPS_DELAY_RST;
      delayActiveReg <= `WPS_DELAY_RST;
    end else if (wrStrobe && !isMem) begin
      case (addrReg)
        `WPS_REG_UPDATE: begin
          if (frameWord[`WPS_UPDATE_BIT]) begin
            delayActiveReg <= delayShadowReg;
          end
        end
        `WPS_REG_STATUS: begin
          runReg <= frameWord[`WPS_RUN_BIT];
          memAccessReg <= frameWord[`WPS_MEMACC_BIT];
          bufReadReg <= frameWord[`WPS_BUFREAD_BIT];
        end
        `WPS_REG_TYPE: repeatTypeReg <= frameWord[`WPS_RPT_BIT];
        `WPS_REG_DELAY: delayShadowReg <= frameWord;
        default: runReg <= runReg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern period control
  reg [2:0] state;
  reg runPrev;
  reg msbPrev;
  reg segDone;
  reg memValid;
  reg [ADDR_W-1:0] addrCnt;
  reg [7:0] sineCnt;
  reg [DATA_W-1:0] sawVal;
  wire [15:0] periodCnt;
  wire [7:0] periodsDone;
  wire msbRise = synthMsb & ~msbPrev;
  wire active = (state == ST_DELAY) || (state == ST_PLAY);
  wire periodEnd = active && (periodCnt == periodLength - 16'h0001);
  wire lastPeriod = repeatTypeReg && (periodsDone + 8'h01 >= repeatCycleCount);
  wire runStart = runReg & ~runPrev & (state == ST_IDLE);
  wire startPeriod = runStart | (periodEnd & ~lastPeriod & runReg);
  wire advance = synthMsbClockSelect ? msbRise : 1'b1;
  wire delayOver = periodCnt + 16'h0001 >= delayActiveReg;

  wps_seq_counter #(.WIDTH(16)) periodCounter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(startPeriod | ~active),
    .enable(active),
    .count(periodCnt)
  );

  wps_seq_counter #(.WIDTH(8)) repeatCounter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(runStart),
    .enable(periodEnd),
    .count(periodsDone)
  );

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      runPrev <= 1'b0;
      msbPrev <= 1'b0;
      segDone <= 1'b0;
      addrCnt <= {ADDR_W{1'b0}};
      sineCnt <= 8'h00;
      sawVal <= {DATA_W{1'b0}};
    end else begin
      runPrev <= runReg;
      msbPrev <= synthMsb;
      if (!runReg) begin
        state <= ST_IDLE;
      end else if (startPeriod) begin
        // A zero delay goes straight to playback, giving gapless periods
        state <= (delayActiveReg == 16'h0000) ? ST_PLAY : ST_DELAY;
        addrCnt <= segFirstAddr;
        segDone <= 1'b0;
        sineCnt <= 8'h00;
        sawVal <= {DATA_W{1'b0}};
      end else if (periodEnd) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_DELAY: begin
            if (delayOver) begin
              state <= ST_PLAY;
            end
          end
          ST_PLAY: begin
            if (advance && !segDone) begin
              if (addrCnt == segLastAddr) begin
                segDone <= 1'b1;
              end else begin
                addrCnt <= addrCnt + {{(ADDR_W-1){1'b0}}, 1'b1};
              end
            end
            if (msbRise && sineCnt != sineCycleCount) begin
              sineCnt <= sineCnt + 8'h01;
            end
            if (sawVal != `WPS_SAW_MAX) begin
              sawVal <= sawVal + {{(DATA_W-1){1'b0}}, 1'b1};
            end
          end
          ST_IDLE: state <= ST_IDLE;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Memory has no reset; contents are whatever software loaded
  always @(posedge core_clk) begin
    if (memWrite) begin
      mem[hostAddr] <= frameWord[DATA_W-1:0];
    end
    memData <= mem[addrCnt];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample datapath
  reg signed [DATA_W-1:0] rawSample;
  wire signed [2*DATA_W-1:0] amProd = synthSine * $signed(memData);
  wire signed [DATA_W+11:0] gainProd = rawSample * $signed(digitalGainFactor);
  wire overflow = (gainProd[DATA_W+11:DATA_W+9] != 3'b000) && (gainProd[DATA_W+11:DATA_W+9] != 3'b111);
  wire playing = (state == ST_PLAY);

  always @* begin
    case (waveSel)
      `WPS_SRC_MEM: rawSample = memValid ? memData : {DATA_W{1'b0}};
      `WPS_SRC_SINE: rawSample = (playing && sineCnt != sineCycleCount) ? synthSine : {DATA_W{1'b0}};
      `WPS_SRC_SAW: rawSample = playing ? sawVal : {DATA_W{1'b0}};
      `WPS_SRC_AM: rawSample = memValid ? amProd[DATA_W-1+`WPS_ENV_FRAC:`WPS_ENV_FRAC] : {DATA_W{1'b0}};
      default: rawSample = {DATA_W{1'b0}};
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memValid <= 1'b0;
      sampleOut <= {DATA_W{1'b0}};
      tuningBits <= {DATA_W{1'b0}};
      patternActive <= 1'b0;
    end else begin
      // Memory read is registered, so the valid flag trails the address by one clock
      memValid <= playing & ~segDone & runReg;
      patternActive <= active & runReg;
      // Gain is clipped rather than wrapped, since wrap would flip polarity
      if (overflow) begin
        sampleOut <= gainProd[DATA_W+11] ? {1'b1, {(DATA_W-1){1'b0}}} : {1'b0, {(DATA_W-1){1'b1}}};
      end else begin
        sampleOut <= gainProd[DATA_W-1+`WPS_GAIN_FRAC:`WPS_GAIN_FRAC];
      end
      if (synthMsbClockSelect && memValid) begin
        tuningBits <= memData;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/wps_seq_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wps_defs.vh"
module wps_seq_monitor #(
  parameter ADDR_W = 12,
  parameter DATA_W = 14
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMiso,
  input wire logic spiMisoEn,
  input wire logic [1:0] waveSel,
  input wire logic synthMsbClockSelect,
  input wire logic [11:0] digitalGainFactor,
  input wire logic [DATA_W-1:0] sampleOut,
  input wire logic [DATA_W-1:0] tuningBits,
  input wire logic patternActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_misoStable;
    spiSclk [*4] |-> $stable(spiMiso);
  endproperty
  a_misoStable: assert property (p_misoStable) else $error("miso moved in clock high");
  property p_misoIdle;
    spiCsN [*8] |-> !spiMisoEn;
  endproperty
  a_misoIdle: assert property (p_misoIdle) else $error("miso enabled while idle");
  property p_misoEnCs;
    $rose(spiMisoEn) |-> !spiCsN;
  endproperty
  a_misoEnCs: assert property (p_misoEnCs) else $error("miso enabled outside frame");
  // Pipeline is two deep, so eight idle cycles must flush it
  property p_idleOut;
    !patternActive [*8] |-> sampleOut == '0;
  endproperty
  a_idleOut: assert property (p_idleOut) else $error("output while idle");
  property p_sawStep;
    waveSel == `WPS_SRC_SAW && $stable(waveSel) && digitalGainFactor == 12'h400
      && $past(sampleOut) != 0 && $past(sampleOut) != 14'h1fff && sampleOut != 0
      && sampleOut != $past(sampleOut) |-> sampleOut == $past(sampleOut) + 14'h0001;
  endproperty
  a_sawStep: assert property (p_sawStep) else $error("ramp step wrong");
  property p_gainZero;
    digitalGainFactor == 12'h000 [*5] |-> sampleOut == '0;
  endproperty
  a_gainZero: assert property (p_gainZero) else $error("zero gain leaks");
  property p_fskHold;
    !synthMsbClockSelect [*4] |-> $stable(tuningBits);
  endproperty
  a_fskHold: assert property (p_fskHold) else $error("tuning moved outside keying");
  property p_fskChange;
    !$stable(tuningBits) |-> synthMsbClockSelect;
  endproperty
  a_fskChange: assert property (p_fskChange) else $error("tuning moved unselected");
endmodule
bind wps_sequencer wps_seq_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) uMon (
  .core_clk(core_clk), .rst_n(rst_n), .spiSclk(spiSclk), .spiCsN(spiCsN),
  .spiMiso(spiMiso), .spiMisoEn(spiMisoEn), .waveSel(waveSel),
  .synthMsbClockSelect(synthMsbClockSelect), .digitalGainFactor(digitalGainFactor),
  .sampleOut(sampleOut), .tuningBits(tuningBits), .patternActive(patternActive));
`default_nettype wire

// [tb/wps_dac_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module wps_dac_sink (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [13:0] sampleIn,
  output logic [13:0] heldSample
);
  // Converter latches each sample on the clock edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) heldSample <= 14'h0000;
    else heldSample <= sampleIn;
  end
endmodule
`default_nettype wire

// [tb/test_waveform_pattern_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wps_defs.vh"
module test_waveform_pattern_sequencer;
  logic core_clk = 0, rst_n = 0, sclk = 0, csN = 1, mosi = 0, msbSel = 0, msb = 0;
  logic [1:0] wSel = 0;
  logic [1:0] ph = 0;
  logic [11:0] gain = 0;
  logic [7:0] rptCnt = 1;
  logic [15:0] perLen = 16'h0008;
  logic [15:0] rd;
  wire miso, misoEn, act;
  wire [13:0] smp, tune, dacSmp;
  int err_count = 0, compares = 0, lat0, lat2, latAm, burst = 0;
  wps_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .spiSclk(sclk), .spiCsN(csN),
    .spiMosi(mosi), .spiMiso(miso), .spiMisoEn(misoEn), .waveSel(wSel),
    .synthMsbClockSelect(msbSel), .segFirstAddr(12'h000), .segLastAddr(12'h001),
    .periodLength(perLen), .repeatCycleCount(rptCnt), .sineCycleCount(8'h02),
    .digitalGainFactor(gain), .synthSine(14'sh0100), .synthMsb(msb), .sampleOut(smp),
    .tuningBits(tune), .patternActive(act));
  wps_dac_sink dac (.core_clk(core_clk), .rst_n(rst_n), .sampleIn(smp), .heldSample(dacSmp));
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) ph <= ph + 2'h1;
  always @(posedge core_clk) msb <= ph[1];
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Slow bit-banged frame keeps the serial clock well under the sync limit
  task automatic xfer(input logic r, input logic [14:0] a, input logic [15:0] d);
    logic [31:0] f;
    f = {r, a, d};
    csN <= 0;
    for (int i = 31; i >= 0; i--) begin
      tick(5);
      mosi <= f[i];
      tick(5);
      sclk <= 1;
      if (i < 16) rd[i] = miso;
      tick(5);
      sclk <= 0;
    end
    tick(5);
    csN <= 1;
    tick(5);
  endtask
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    xfer(0, a, d);
  endtask
  task automatic rdChk(input logic [14:0] a, input logic [15:0] e);
    xfer(1, a, 16'h0000);
    cmp(rd, e);
  endtask
  // RUN lands before the frame ends, so the watch runs beside the write
  task automatic runPair(input logic [13:0] s0, input logic [13:0] s1, output int n);
    n = 0;
    fork
      wr(`WPS_REG_STATUS, 16'h0001);
      begin
        for (int k = 0; k < 700 && act !== 1'b1; k++) tick(1);
        while (dacSmp !== s0 && n < 300) begin
          tick(1);
          n++;
        end
        tick(1);
        cmp(dacSmp, {2'b00, s1});
      end
    join
  endtask
  task automatic runLat(input logic [15:0] dly, output int n);
    wr(`WPS_REG_DELAY, dly);
    wr(`WPS_REG_UPDATE, 16'h0001);
    runPair(14'h0123, 14'h0456, n);
    tick(16);
    cmp(act, 1'b0);
    wr(`WPS_REG_STATUS, 16'h0000);
  endtask
  task automatic print_verdict;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    tick(40000);
    err_count++;
    print_verdict;
  end
  initial begin
    tick(3);
    rst_n <= 1;
    tick(8);
    rdChk(`WPS_REG_STATUS, 16'h0000);
    rdChk(`WPS_REG_TYPE, 16'h0000);
    rdChk(`WPS_REG_DELAY, 16'h0000);
    rdChk(15'h0010, 16'h0000);
    gain <= 12'h400;
    wr(`WPS_REG_TYPE, 16'h0001);
    rdChk(`WPS_REG_TYPE, 16'h0001);
    wr(`WPS_REG_STATUS, 16'h0004);
    wr(15'h6000, 16'h0123);
    wr(15'h6001, 16'h0456);
    wr(`WPS_REG_STATUS, 16'h0000);
    wr(15'h6000, 16'h3fff);
    wr(`WPS_REG_STATUS, 16'h000c);
    rdChk(15'h6000, 16'h0123);
    rdChk(15'h6001, 16'h0456);
    runLat(16'h0002, lat2);
    runLat(16'h0000, lat0);
    cmp(16'(lat2 - lat0), 16'h0002);
    wSel <= `WPS_SRC_SAW;
    wr(`WPS_REG_TYPE, 16'h0000);
    wr(`WPS_REG_STATUS, 16'h0001);
    rdChk(`WPS_REG_STATUS, 16'h0003);
    // Host access while running only reaches addresses outside the segment
    wr(`WPS_REG_STATUS, 16'h0005);
    wr(15'h6001, 16'h3fff);
    wr(15'h6002, 16'h0789);
    wr(`WPS_REG_STATUS, 16'h000d);
    rdChk(15'h6000, 16'h0000);
    rdChk(15'h6002, 16'h0789);
    wr(`WPS_REG_STATUS, 16'h0000);
    tick(12);
    cmp(act, 1'b0);
    wr(`WPS_REG_STATUS, 16'h000c);
    rdChk(15'h6001, 16'h0456);
    wSel <= `WPS_SRC_MEM;
    msbSel <= 1;
    wr(`WPS_REG_STATUS, 16'h0001);
    for (int k = 0; k < 200 && tune !== 14'h0123; k++) tick(1);
    cmp(tune, 16'h0123);
    for (int k = 0; k < 200 && tune !== 14'h0456; k++) tick(1);
    cmp(tune, 16'h0456);
    wr(`WPS_REG_STATUS, 16'h0000);
    tick(20);
    msbSel <= 0;
    tick(20);
    wSel <= `WPS_SRC_AM;
    gain <= 12'h200;
    perLen <= 16'h0010;
    wr(`WPS_REG_TYPE, 16'h0001);
    runPair(14'h0004, 14'h0011, latAm);
    wr(`WPS_REG_STATUS, 16'h0000);
    wSel <= `WPS_SRC_SINE;
    gain <= 12'h400;
    fork
      wr(`WPS_REG_STATUS, 16'h0001);
      begin
        for (int k = 0; k < 700 && act !== 1'b1; k++) tick(1);
        repeat (40) begin
          tick(1);
          if (dacSmp === 14'h0100) burst++;
        end
      end
    join
    // Two cycles of a four-clock MSB give five to eight samples, by phase
    cmp(16'(burst >= 5 && burst <= 8), 16'h0001);
    wr(`WPS_REG_STATUS, 16'h0000);
    print_verdict;
  end
endmodule
`default_nettype wire
